// File: smart_pkg.sv
// constants shared by the health-monitoring sector builder and its divider
package smart_pkg;

  // ---------------------------------------------------------------------
  // flash array shape
  // ---------------------------------------------------------------------
  localparam int NUM_CHIPS = 4;
  localparam int CHIP_W = 2;

  // ---------------------------------------------------------------------
  // task-file command codes and answers
  // ---------------------------------------------------------------------
  localparam logic [7:0] FEAT_READ_DATA = 8'hD0;
  localparam logic [7:0] FEAT_READ_THR = 8'hD1;
  localparam logic [7:0] FEAT_STATUS = 8'hDA;
  localparam logic [7:0] SIG_CYL_LOW = 8'h4F;
  localparam logic [7:0] SIG_CYL_HIGH = 8'hC2;
  localparam logic [7:0] FAIL_CYL_LOW = 8'hF4;
  localparam logic [7:0] FAIL_CYL_HIGH = 8'h2C;

  // ---------------------------------------------------------------------
  // attribute identifiers, flags and fixed values
  // ---------------------------------------------------------------------
  localparam logic [7:0] ID_SPARE = 8'hC4;
  localparam logic [7:0] ID_ERASE = 8'hE5;
  localparam logic [7:0] ID_ECC_TOTAL = 8'hCB;
  localparam logic [7:0] ID_ECC_CORR = 8'hCC;
  localparam logic [7:0] ID_READS = 8'hE8;
  localparam logic [7:0] ID_UDMA_CRC = 8'hC7;
  localparam logic [15:0] FLAGS_PREFAIL = 16'h0003;
  localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;
  localparam logic [15:0] SECTOR_VERSION = 16'h0004;
  localparam logic [7:0] FIXED_VALUE = 8'h64;
  localparam logic [7:0] PCT_SCALE = 8'h64;
  localparam logic [7:0] FULL_PCT = 8'h64;

  // ---------------------------------------------------------------------
  // sector layout and timing
  // ---------------------------------------------------------------------
  localparam logic [8:0] OFS_VERSION_HI = 9'h001;
  localparam logic [8:0] OFS_ENTRIES = 9'h002;
  localparam logic [8:0] ENTRY_BYTES = 9'h00C;
  localparam logic [8:0] USED_ENTRY_BYTES = 9'h048;
  localparam logic [8:0] OFS_CHECKSUM = 9'h1FF;
  localparam logic [4:0] DIV_STEPS = 5'h18;

endpackage

// File: pct_divider.sv
// sequential divider giving 100 * current / initial spare blocks
`timescale 1ns/1ps

module pct_divider (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [15:0] i_cur,
  input wire logic [15:0] i_init,
  output logic o_done,
  output logic [7:0] o_pct
);

  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic [23:0] num;
    logic [15:0] den;
    logic [15:0] rem;
    logic [23:0] quot;
    logic done;
    logic [7:0] pct;
  } div_state_t;

  div_state_t r;
  div_state_t next_r;
  logic [16:0] trial;
  logic [23:0] q_new;

  // ---------------------------------------------------------------------
  // restoring division, one quotient bit per clock
  // ---------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    trial = {r.rem, r.num[23]};
    q_new = {r.quot[22:0], trial >= {1'b0, r.den}};
    if (i_start) begin
      // a chip with no spares at all is reported as untouched
      if (i_init == 16'h0000) begin
        next_r.done = 1'b1;
        next_r.pct = smart_pkg::FULL_PCT;
      end else begin
        next_r.busy = 1'b1;
        next_r.cnt = smart_pkg::DIV_STEPS;
        next_r.num = 24'(i_cur) * 24'(smart_pkg::PCT_SCALE);
        next_r.den = i_init;
        next_r.rem = 16'h0000;
        next_r.quot = 24'h000000;
      end
    end else if (r.busy) begin
      if (trial >= {1'b0, r.den}) begin
        next_r.rem = 16'(trial - {1'b0, r.den});
      end else begin
        next_r.rem = trial[15:0];
      end
      next_r.quot = q_new;
      next_r.num = {r.num[22:0], 1'b0};
      next_r.cnt = 5'(r.cnt - 5'h01);
      if (r.cnt == 5'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        // a quotient above FFh saturates to FFh rather than wrapping; 101 to 255 pass through
        next_r.pct = (|q_new[23:8]) ? 8'hFF : q_new[7:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_done = r.done;
  assign o_pct = r.pct;

endmodule // pct_divider

// File: smart_reporter.sv
// health-monitoring attribute and threshold sectors with status check
//
// Overview of operation
// - spare entry: id C4h, flags 0003h
// - spare value: minimum chip spare percentage
// - bytes 4-7: initial, current of minimum chip
// - bytes 8-11: initial and current totals
// - spare value below threshold means exceeded
// - erase entry: id E5h, flags 0002h
// - erase value remaining life; bytes 4-11 erases
// - erase value below threshold means exceeded
// - entry CBh counts every ECC error
// - entry CCh counts correctable ECC errors
// - entry E8h holds flash read total
// - entry C7h counts UDMA CRC errors
// - four counter entries advisory, never judged
// - counter entries value byte fixed 64h
// - threshold sector: version, 6 entries, checksum
// - spare threshold entry: C4h then threshold
// - erase threshold entry: E5h then threshold
// - status answer F4h/2Ch else 4Fh/C2h
`timescale 1ns/1ps

module smart_reporter (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_feature,
  input wire logic [7:0] i_cmd_cyl_low,
  input wire logic [7:0] i_cmd_cyl_high,
  input wire logic [smart_pkg::NUM_CHIPS-1:0][15:0] i_spare_init,
  input wire logic [smart_pkg::NUM_CHIPS-1:0][15:0] i_spare_cur,
  input wire logic [7:0] i_life_pct,
  input wire logic [63:0] i_erase_total,
  input wire logic [7:0] i_spare_thr,
  input wire logic [7:0] i_erase_thr,
  input wire logic i_ecc_err,
  input wire logic i_ecc_corr,
  input wire logic i_flash_read,
  input wire logic i_crc_err,
  input wire logic i_data_ready,
  output logic o_busy,
  output logic o_data_valid,
  output logic [7:0] o_data,
  output logic o_data_last,
  output logic o_status_valid,
  output logic [7:0] o_cyl_low,
  output logic [7:0] o_cyl_high,
  output logic o_abort
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DIV_GO,
    ST_DIV_WAIT,
    ST_SEND,
    ST_STATUS
  } state_t;

  typedef struct packed {
    state_t st;
    logic is_thr;
    logic is_status;
    logic [smart_pkg::CHIP_W-1:0] chip;
    logic div_go;
    logic [7:0] min_pct;
    logic [15:0] min_init;
    logic [15:0] min_cur;
    logic [15:0] sum_init;
    logic [15:0] sum_cur;
    logic [7:0] life;
    logic [63:0] erases;
    logic [7:0] thr_spare;
    logic [7:0] thr_erase;
    logic [31:0] snap_ecc;
    logic [31:0] snap_corr;
    logic [63:0] snap_reads;
    logic [31:0] snap_crc;
    logic [31:0] ecc;
    logic [31:0] corr;
    logic [63:0] reads;
    logic [31:0] crc;
    logic [8:0] idx;
    logic [7:0] csum;
    logic busy;
    logic dvalid;
    logic [7:0] data;
    logic last;
    logic svalid;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic abort;
  } smart_state_t;

  smart_state_t r;
  smart_state_t next_r;
  logic div_done;
  logic [7:0] div_pct;
  logic [17:0] acc_init [0:smart_pkg::NUM_CHIPS];
  logic [17:0] acc_cur [0:smart_pkg::NUM_CHIPS];
  logic sig_ok;
  logic feat_ok;
  logic exceeded;
  logic [8:0] idx_inc;
  logic [7:0] csum_inc;

  // ---------------------------------------------------------------------
  // spare totals over all chips
  // ---------------------------------------------------------------------
  assign acc_init[0] = 18'h00000;
  assign acc_cur[0] = 18'h00000;
  genvar g;
  generate
    for (g = 0; g < smart_pkg::NUM_CHIPS; g++) begin : g_sum
      assign acc_init[g+1] = acc_init[g] + 18'(i_spare_init[g]);
      assign acc_cur[g+1] = acc_cur[g] + 18'(i_spare_cur[g]);
    end
  endgenerate

  pct_divider u_div (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_start(r.div_go),
    .i_cur(i_spare_cur[r.chip]),
    .i_init(i_spare_init[r.chip]),
    .o_done(div_done),
    .o_pct(div_pct)
  );

  // ---------------------------------------------------------------------
  // sector byte at a given offset
  // ---------------------------------------------------------------------
  function automatic logic [7:0] sector_byte(input smart_state_t s,
                                             input logic [8:0] idx);
    logic [8:0] rel;
    logic [2:0] k;
    logic [3:0] off;
    logic [95:0] e;
    rel = 9'(idx - smart_pkg::OFS_ENTRIES);
    k = 3'(rel / smart_pkg::ENTRY_BYTES);
    off = 4'(rel % smart_pkg::ENTRY_BYTES);
    e = '0;
    if (s.is_thr) begin
      unique case (k)
        3'h0: e = {80'h0, s.thr_spare, smart_pkg::ID_SPARE};
        3'h1: e = {80'h0, s.thr_erase, smart_pkg::ID_ERASE};
        3'h2: e = {88'h0, smart_pkg::ID_ECC_TOTAL};
        3'h3: e = {88'h0, smart_pkg::ID_ECC_CORR};
        3'h4: e = {88'h0, smart_pkg::ID_READS};
        3'h5: e = {88'h0, smart_pkg::ID_UDMA_CRC};
        default: e = '0;
      endcase
    end else begin
      unique case (k)
        3'h0: e = {s.sum_cur, s.sum_init, s.min_cur, s.min_init,
                   s.min_pct, smart_pkg::FLAGS_PREFAIL,
                   smart_pkg::ID_SPARE};
        3'h1: e = {s.erases, s.life, smart_pkg::FLAGS_ADVISORY,
                   smart_pkg::ID_ERASE};
        3'h2: e = {32'h0, s.snap_ecc, smart_pkg::FIXED_VALUE,
                   smart_pkg::FLAGS_ADVISORY, smart_pkg::ID_ECC_TOTAL};
        3'h3: e = {32'h0, s.snap_corr, smart_pkg::FIXED_VALUE,
                   smart_pkg::FLAGS_ADVISORY, smart_pkg::ID_ECC_CORR};
        3'h4: e = {s.snap_reads, smart_pkg::FIXED_VALUE,
                   smart_pkg::FLAGS_ADVISORY, smart_pkg::ID_READS};
        3'h5: e = {32'h0, s.snap_crc, smart_pkg::FIXED_VALUE,
                   smart_pkg::FLAGS_ADVISORY, smart_pkg::ID_UDMA_CRC};
        default: e = '0;
      endcase
    end
    if (idx == 9'h000) begin
      return smart_pkg::SECTOR_VERSION[7:0];
    end else if (idx == smart_pkg::OFS_VERSION_HI) begin
      return smart_pkg::SECTOR_VERSION[15:8];
    end else if (rel < smart_pkg::USED_ENTRY_BYTES) begin
      return e[{off, 3'b000} +: 8];
    end
    // unused entries and the tail up to the checksum read as zero
    return 8'h00;
  endfunction

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  assign sig_ok = (i_cmd_cyl_low == smart_pkg::SIG_CYL_LOW) &&
                  (i_cmd_cyl_high == smart_pkg::SIG_CYL_HIGH);
  assign feat_ok = (i_cmd_feature == smart_pkg::FEAT_READ_DATA) ||
                   (i_cmd_feature == smart_pkg::FEAT_READ_THR) ||
                   (i_cmd_feature == smart_pkg::FEAT_STATUS);
  // only the spare and erase values are judged; counters never are
  assign exceeded = (r.min_pct < r.thr_spare) ||
                    (r.life < r.thr_erase);
  assign idx_inc = 9'(r.idx + 9'h001);
  assign csum_inc = 8'(r.csum + r.data);

  always_comb begin
    next_r = r;
    next_r.div_go = 1'b0;
    next_r.svalid = 1'b0;
    next_r.abort = 1'b0;
    // counters saturate instead of wrapping to zero
    if (i_ecc_err && !(&r.ecc)) next_r.ecc = r.ecc + 32'h1;
    if (i_ecc_corr && !(&r.corr)) next_r.corr = r.corr + 32'h1;
    if (i_flash_read && !(&r.reads)) next_r.reads = r.reads + 64'h1;
    if (i_crc_err && !(&r.crc)) next_r.crc = r.crc + 32'h1;
    unique case (r.st)
      ST_IDLE: begin
        if (i_cmd_valid && sig_ok && feat_ok) begin
          next_r.st = ST_DIV_GO;
          next_r.busy = 1'b1;
          next_r.is_thr = (i_cmd_feature == smart_pkg::FEAT_READ_THR);
          next_r.is_status = (i_cmd_feature == smart_pkg::FEAT_STATUS);
          next_r.chip = '0;
          // every sector field is latched before the first byte goes out so multi-byte counts
          // cannot tear while the host drains it
          next_r.snap_ecc = r.ecc;
          next_r.snap_corr = r.corr;
          next_r.snap_reads = r.reads;
          next_r.snap_crc = r.crc;
          next_r.erases = i_erase_total;
          next_r.life = (i_life_pct > smart_pkg::FULL_PCT) ?
                        smart_pkg::FULL_PCT : i_life_pct;
          next_r.thr_spare = i_spare_thr;
          next_r.thr_erase = i_erase_thr;
          next_r.sum_init = (|acc_init[smart_pkg::NUM_CHIPS][17:16]) ?
                            16'hFFFF : acc_init[smart_pkg::NUM_CHIPS][15:0];
          next_r.sum_cur = (|acc_cur[smart_pkg::NUM_CHIPS][17:16]) ?
                           16'hFFFF : acc_cur[smart_pkg::NUM_CHIPS][15:0];
        end else if (i_cmd_valid) begin
          next_r.abort = 1'b1;
        end
      end
      ST_DIV_GO: begin
        next_r.div_go = 1'b1;
        next_r.st = ST_DIV_WAIT;
      end
      ST_DIV_WAIT: begin
        if (div_done) begin
          if ((r.chip == '0) || (div_pct < r.min_pct)) begin
            next_r.min_pct = div_pct;
            next_r.min_init = i_spare_init[r.chip];
            next_r.min_cur = i_spare_cur[r.chip];
          end
          if (r.chip == smart_pkg::CHIP_W'(smart_pkg::NUM_CHIPS - 1)) begin
            if (r.is_status) begin
              next_r.st = ST_STATUS;
            end else begin
              next_r.st = ST_SEND;
              next_r.idx = 9'h000;
              next_r.csum = 8'h00;
              next_r.dvalid = 1'b1;
              next_r.data = smart_pkg::SECTOR_VERSION[7:0];
              next_r.last = 1'b0;
            end
          end else begin
            next_r.chip = smart_pkg::CHIP_W'(r.chip + 1'b1);
            next_r.st = ST_DIV_GO;
          end
        end
      end
      ST_SEND: begin
        if (i_data_ready) begin
          next_r.csum = csum_inc;
          if (r.last) begin
            next_r.st = ST_IDLE;
            next_r.dvalid = 1'b0;
            next_r.last = 1'b0;
            next_r.busy = 1'b0;
          end else begin
            next_r.idx = idx_inc;
            next_r.last = (idx_inc == smart_pkg::OFS_CHECKSUM);
            next_r.data = (idx_inc == smart_pkg::OFS_CHECKSUM) ?
                          8'(8'h00 - csum_inc) :
                          sector_byte(r, idx_inc);
          end
        end
      end
      ST_STATUS: begin
        next_r.st = ST_IDLE;
        next_r.busy = 1'b0;
        next_r.svalid = 1'b1;
        next_r.cyl_low = exceeded ? smart_pkg::FAIL_CYL_LOW :
                         smart_pkg::SIG_CYL_LOW;
        next_r.cyl_high = exceeded ? smart_pkg::FAIL_CYL_HIGH :
                          smart_pkg::SIG_CYL_HIGH;
      end
      default: begin
        next_r.st = ST_IDLE;
        next_r.busy = 1'b0;
        next_r.dvalid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_busy = r.busy;
  assign o_data_valid = r.dvalid;
  assign o_data = r.data;
  assign o_data_last = r.last;
  assign o_status_valid = r.svalid;
  assign o_cyl_low = r.cyl_low;
  assign o_cyl_high = r.cyl_high;
  assign o_abort = r.abort;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  spare_id_a: assert property (
    o_data_valid && !r.is_thr && (r.idx == 9'h002 || r.idx == 9'h003) |->
      o_data == ((r.idx == 9'h002) ? 8'hC4 : 8'h03))
    else $error("spare entry id or flags wrong");

  erase_id_a: assert property (
    o_data_valid && !r.is_thr && r.idx == 9'h00E |-> o_data == 8'hE5)
    else $error("erase entry id wrong");

  fixed_val_a: assert property (
    o_data_valid && !r.is_thr &&
    (r.idx == 9'h01D || r.idx == 9'h029 || r.idx == 9'h035 ||
     r.idx == 9'h041) |-> o_data == 8'h64)
    else $error("counter entry value not fixed");

  sector_version_a: assert property (
    $rose(o_data_valid) |-> o_data == 8'h04 && r.idx == 9'h000
      ##1 (!o_data_valid || r.idx == 9'h000 || o_data == 8'h00))
    else $error("sector version wrong");

  thr_entry_a: assert property (
    o_data_valid && r.is_thr && r.idx == 9'h003 |-> o_data == r.thr_spare)
    else $error("spare threshold byte wrong");

  sector_checksum_a: assert property (
    o_data_valid && o_data_last && i_data_ready |->
      8'(r.csum + o_data) == 8'h00 && r.idx == 9'h1FF
      ##1 !o_data_valid && !o_busy)
    else $error("sector checksum wrong");

  status_answer_a: assert property (
    r.st == ST_STATUS |=> o_status_valid &&
      ((o_cyl_low == 8'hF4) == $past(exceeded)) &&
      ((o_cyl_high == 8'h2C) == $past(exceeded)))
    else $error("status answer does not match thresholds");

  status_pair_a: assert property (
    o_status_valid |-> (o_cyl_low == 8'hF4 && o_cyl_high == 8'h2C) ||
      (o_cyl_low == 8'h4F && o_cyl_high == 8'hC2))
    else $error("status answer pair mixed");

  ecc_count_a: assert property (
    i_ecc_err && !(&r.ecc) |=> r.ecc == $past(r.ecc) + 32'h1)
    else $error("ecc counter missed an event");

  data_hold_a: assert property (
    o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data))
    else $error("data changed while stalled");

  bad_sig_a: assert property (
    !o_busy && i_cmd_valid && !sig_ok |=> o_abort && !o_busy)
    else $error("bad signature not aborted");

  data_done_c: cover property (
    o_data_valid && o_data_last && i_data_ready && !r.is_thr);
  thr_done_c: cover property (
    o_data_valid && o_data_last && i_data_ready && r.is_thr);
  status_fail_c: cover property (o_status_valid && o_cyl_low == 8'hF4);
  abort_c: cover property (o_abort);

endmodule // smart_reporter

// File: ata_host_model.sv
// host model: issues health commands and sinks sector bytes
`timescale 1ns/1ps

module ata_host_model (
  input wire logic i_ref_clk,
  input wire logic i_data_valid,
  input wire logic [7:0] i_data,
  input wire logic i_data_last,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_feature,
  output logic [7:0] o_cmd_cyl_low,
  output logic [7:0] o_cmd_cyl_high,
  output logic o_data_ready
);
  logic [7:0] sect [512];
  int n_rx = 0;
  int last_idx = -1;
  logic slow = 1'b0;
  logic [1:0] pace = 2'h0;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_feature = 8'h00;
    o_cmd_cyl_low = 8'h00;
    o_cmd_cyl_high = 8'h00;
  end

  // ---------------------------------------------------------------------
  // byte sink
  // ---------------------------------------------------------------------
  // slow mode takes one byte in four so the stream has to hold its data
  always @(posedge i_ref_clk) begin
    pace <= pace + 2'h1;
    o_data_ready <= !slow || (pace == 2'h3);
    if (i_data_valid && o_data_ready && n_rx < 512) begin
      sect[n_rx] <= i_data;
      if (i_data_last) begin
        last_idx <= n_rx;
      end
      n_rx <= n_rx + 1;
    end
  end

  // ---------------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------------
  task automatic send_cmd(input logic [7:0] feat, input logic [7:0] lo,
                          input logic [7:0] hi);
    @(posedge i_ref_clk);
    o_cmd_feature <= feat;
    o_cmd_cyl_low <= lo;
    o_cmd_cyl_high <= hi;
    o_cmd_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
    // registers are stale after the strobe; no reliance on them
    o_cmd_feature <= ~feat;
  endtask
endmodule // ata_host_model

// File: smart_reporter_tb_top.sv
// self-checking bench for the health sector builder
`timescale 1ns/1ps

module smart_reporter_tb_top;
  logic clk;
  logic rstn;
  logic [smart_pkg::NUM_CHIPS-1:0][15:0] spare_init;
  logic [smart_pkg::NUM_CHIPS-1:0][15:0] spare_cur;
  logic [7:0] life_pct;
  logic [63:0] erase_total;
  logic [7:0] spare_thr;
  logic [7:0] erase_thr;
  logic ecc_err;
  logic ecc_corr;
  logic flash_read;
  logic crc_err;
  logic cmd_valid;
  logic [7:0] cmd_feature;
  logic [7:0] cmd_cyl_low;
  logic [7:0] cmd_cyl_high;
  logic data_ready;
  logic busy;
  logic data_valid;
  logic [7:0] data;
  logic data_last;
  logic status_valid;
  logic [7:0] cyl_low;
  logic [7:0] cyl_high;
  logic abort;
  logic [7:0] exp_b [512];
  int error_cnt = 0;
  int n_compared = 0;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ata_host_model host (.i_ref_clk(clk), .i_data_valid(data_valid),
    .i_data(data), .i_data_last(data_last), .o_cmd_valid(cmd_valid),
    .o_cmd_feature(cmd_feature), .o_cmd_cyl_low(cmd_cyl_low),
    .o_cmd_cyl_high(cmd_cyl_high), .o_data_ready(data_ready));

  smart_reporter dut (.i_ref_clk(clk), .i_rstn(rstn),
    .i_cmd_valid(cmd_valid), .i_cmd_feature(cmd_feature),
    .i_cmd_cyl_low(cmd_cyl_low), .i_cmd_cyl_high(cmd_cyl_high),
    .i_spare_init(spare_init), .i_spare_cur(spare_cur),
    .i_life_pct(life_pct), .i_erase_total(erase_total),
    .i_spare_thr(spare_thr), .i_erase_thr(erase_thr), .i_ecc_err(ecc_err),
    .i_ecc_corr(ecc_corr), .i_flash_read(flash_read), .i_crc_err(crc_err),
    .i_data_ready(data_ready), .o_busy(busy), .o_data_valid(data_valid),
    .o_data(data), .o_data_last(data_last), .o_status_valid(status_valid),
    .o_cyl_low(cyl_low), .o_cyl_high(cyl_high), .o_abort(abort));

  // ---------------------------------------------------------------------
  // compare, report and expectation helpers
  // ---------------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] want,
                     input string what);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("FAIL %0t %s got %0h want %0h", $time, what, got, want);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic void put(input int ofs, input logic [63:0] v,
                              input int n);
    for (int k = 0; k < n; k++) begin
      exp_b[ofs + k] = v[8 * k +: 8];
    end
  endfunction

  function automatic void build_exp(input logic is_data);
    logic [7:0] ids [6];
    int mi;
    int best;
    int pct;
    int si;
    int sc;
    logic [7:0] sum;
    ids = '{8'hC4, 8'hE5, 8'hCB, 8'hCC, 8'hE8, 8'hC7};
    mi = 0;
    best = 1000;
    si = 0;
    sc = 0;
    sum = 8'h00;
    for (int b = 0; b < 512; b++) begin
      exp_b[b] = 8'h00;
    end
    exp_b[0] = 8'h04;
    for (int e = 0; e < 6; e++) begin
      exp_b[2 + 12 * e] = ids[e];
      if (is_data) begin
        exp_b[3 + 12 * e] = (e == 0) ? 8'h03 : 8'h02;
      end
      if (is_data && e > 1) begin
        exp_b[5 + 12 * e] = 8'h64;
      end
    end
    for (int c = 0; c < smart_pkg::NUM_CHIPS; c++) begin
      pct = 100 * int'(spare_cur[c]) / int'(spare_init[c]);
      si += int'(spare_init[c]);
      sc += int'(spare_cur[c]);
      if (pct < best) begin
        best = pct;
        mi = c;
      end
    end
    if (is_data) begin
      exp_b[5] = 8'(best);
      put(6, 64'(spare_init[mi]), 2);
      put(8, 64'(spare_cur[mi]), 2);
      put(10, 64'(si), 2);
      put(12, 64'(sc), 2);
      exp_b[17] = life_pct;
      put(18, erase_total, 8);
      put(30, 64'h3, 4);
      put(42, 64'h2, 4);
      put(54, 64'h5, 8);
      put(66, 64'h1, 4);
    end else begin
      exp_b[3] = spare_thr;
      exp_b[15] = erase_thr;
    end
    for (int b = 0; b < 511; b++) begin
      sum = sum + exp_b[b];
    end
    exp_b[511] = 8'h00 - sum;
  endfunction

  // waits for a whole sector; the sector ends with busy released
  task automatic read_sector(input logic is_data, input logic stall);
    int k;
    host.n_rx = 0;
    host.last_idx = -1;
    host.slow = stall;
    host.send_cmd(is_data ? 8'hD0 : 8'hD1, 8'h4F, 8'hC2);
    for (k = 0; k < 4000; k++) begin
      @(negedge clk);
      if (host.n_rx == 512 && busy === 1'b0) break;
    end
    if (k == 4000) begin
      error_cnt++;
      $display("FAIL %0t sector transfer timed out", $time);
      print_verdict();
    end
    build_exp(is_data);
    for (int b = 0; b < 512; b++) begin
      cmp({8'h00, host.sect[b]}, {8'h00, exp_b[b]}, "sector byte");
    end
    cmp(16'(host.last_idx), 16'h01FF, "last byte index");
    cmp({15'h0000, data_valid}, 16'h0000, "valid after end");
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_data_sector();
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      ecc_err <= (k < 3);
      ecc_corr <= (k < 2);
      flash_read <= 1'b1;
      crc_err <= (k < 1);
      @(posedge clk);
      ecc_err <= 1'b0;
      ecc_corr <= 1'b0;
      flash_read <= 1'b0;
      crc_err <= 1'b0;
    end
    read_sector(1'b1, 1'b1);
    $display("test data_sector done");
  endtask

  task automatic t_thr_sector();
    read_sector(1'b0, 1'b0);
    $display("test thr_sector done");
  endtask

  task automatic run_status(input logic [7:0] sthr, input logic [7:0] ethr,
                            input logic fail);
    int k;
    @(posedge clk);
    spare_thr <= sthr;
    erase_thr <= ethr;
    host.send_cmd(8'hDA, 8'h4F, 8'hC2);
    for (k = 0; k < 1000; k++) begin
      @(negedge clk);
      if (status_valid === 1'b1) break;
    end
    if (k == 1000) begin
      error_cnt++;
      $display("FAIL %0t status answer timed out", $time);
      print_verdict();
    end
    cmp({8'h00, cyl_low}, fail ? 16'h00F4 : 16'h004F, "cyl low");
    cmp({8'h00, cyl_high}, fail ? 16'h002C : 16'h00C2, "cyl high");
  endtask

  // spare minimum is 3Ch and life 32h; equal is not below
  task automatic t_status();
    run_status(8'h3C, 8'h32, 1'b0);
    run_status(8'h3D, 8'h32, 1'b1);
    run_status(8'h3C, 8'h33, 1'b1);
    run_status(8'h00, 8'h00, 1'b0);
    $display("test status done");
  endtask

  task automatic run_abort(input logic [7:0] f, input logic [7:0] lo,
                           input logic [7:0] hi);
    logic seen;
    seen = 1'b0;
    host.send_cmd(f, lo, hi);
    repeat (4) begin
      @(negedge clk);
      seen = seen | (abort === 1'b1);
    end
    cmp({15'h0000, seen}, 16'h0001, "abort pulse");
    cmp({15'h0000, busy}, 16'h0000, "busy after abort");
  endtask

  task automatic t_abort();
    run_abort(8'hD2, 8'h4F, 8'hC2);
    run_abort(8'hD0, 8'h00, 8'hC2);
    run_abort(8'hD1, 8'h4F, 8'h00);
    run_abort(8'hDA, 8'hF4, 8'h2C);
    $display("test abort done");
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    spare_init = {16'h0028, 16'h0032, 16'h00C8, 16'h0064};
    spare_cur = {16'h0028, 16'h001E, 16'h0096, 16'h005A};
    life_pct = 8'h32;
    erase_total = 64'h0000_0012_3456_789A;
    spare_thr = 8'h3C;
    erase_thr = 8'h32;
    ecc_err = 1'b0;
    ecc_corr = 1'b0;
    flash_read = 1'b0;
    crc_err = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_data_sector();
    t_thr_sector();
    t_status();
    t_abort();
    print_verdict();
  end
endmodule // smart_reporter_tb_top
